/* File: pkg/pvs_pkg.sv */
// Purpose: Shared constants for the PHY vendor register bank and its controller
// Assumes: 125 MHz clock, 16-bit management words, 5-bit register index
// Notes: Constants only; no logic here
// Contract
// - Count invalid 100M symbols, idle ones included
// - At most one count per received packet
// - Tally wraps to zero past its maximum
// - Reset clears tally; reads keep it; 10M frozen
// - Auto crossover unless disable bit set
// - Pair swap: 0 MDI, 1 MDIX
// - Heartbeat test on at 0, off at 1
// - Bit 4 shows 10M receive polarity
// - Flags 7..4: energy, negotiation, fault, link down
// - Flags 3..1: ack, parallel fault, page; 0 reserved
// - Mask 7:1 gates flags, 1 enables, resets 0
// - Bit 12 shows negotiation finished
// - Coder enable resets 1; bypass only in MII; code bypasses in any mode when enable is 0
// - Field 4:2 reports resolved speed and duplex
// - MMD space reached only through two registers
// - Only MMD devices 3, 7 and 30 answer
// - Only the listed MMD indexes exist
// - First write control: address function, device
// - Then write index; device latches pointer
// - Then write control: data function, same device
// - Then data register read or write hits MMD
// - Energy drops after 256 ms silence; flags bit 7
package pvs_pkg;
	// ==========================================
	// Management register map
	localparam int DW = 16;
	localparam int AW = 5;
	localparam logic [4:0] ADDR_MMD_CTRL = 5'h0d;
	localparam logic [4:0] ADDR_MMD_DATA = 5'h0e;
	localparam logic [4:0] ADDR_SYM = 5'h1a;
	localparam logic [4:0] ADDR_XOVER = 5'h1b;
	localparam logic [4:0] ADDR_FLAGS = 5'h1d;
	localparam logic [4:0] ADDR_MASK = 5'h1e;
	localparam logic [4:0] ADDR_STAT = 5'h1f;
	// ==========================================
	// Field positions
	localparam int XOVER_AUTO_DIS_BIT = 15;
	localparam int PAIR_SWAP_BIT = 13;
	localparam int SQE_OFF_BIT = 11;
	localparam int POL_BIT = 4;
	localparam int FLAG_LSB = 1;
	localparam int FLAG_MSB = 7;
	localparam int DONE_BIT = 12;
	localparam int CODER_BIT = 6;
	localparam int SPD_LSB = 2;
	localparam int SPD_MSB = 4;
	localparam int FN_LSB = 14;
	localparam int FN_MSB = 15;
	localparam int MMD_DEVICE_SELECT_MSB = 4;
	localparam logic [15:0] SYM_RST = 16'h0000;
	localparam logic [6:0] MASK_RST = 7'h00;
	// ==========================================
	// MMD indirect access
	localparam logic [1:0] FN_ADDR = 2'h0;
	localparam logic [1:0] FN_DATA = 2'h1;
	localparam int MMD_SLOTS = 17;
	localparam logic [4:0] MMD_NONE = 5'h1f;
	// Each entry is {device, index}; storage slot is the entry position
	localparam logic [MMD_SLOTS-1:0][20:0] MMD_MAP = {
		{5'h1e, 16'h000f}, {5'h1e, 16'h000e}, {5'h1e, 16'h0008},
		{5'h1e, 16'h0006}, {5'h1e, 16'h0005}, {5'h1e, 16'h0003},
		{5'h1e, 16'h0002}, {5'h07, 16'h003d}, {5'h07, 16'h003c},
		{5'h07, 16'h0006}, {5'h07, 16'h0005}, {5'h03, 16'h0016},
		{5'h03, 16'h0014}, {5'h03, 16'h0006}, {5'h03, 16'h0005},
		{5'h03, 16'h0001}, {5'h03, 16'h0000}};
	// Devices-present words of the PCS; others start clear
	localparam logic [MMD_SLOTS-1:0][15:0] MMD_RST = {
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h4000, 16'h0088, 16'h0000, 16'h0000};
	// ==========================================
	// Timing
	localparam longint CLK_HZ = 125_000_000;
	localparam longint ENERGY_TIMEOUT_MS = 256;
	localparam longint ENERGY_CYCLES = ENERGY_TIMEOUT_MS * (CLK_HZ / 1000);
	// ==========================================
	// Controller AHB-Lite register map
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_MMD_OP = 8'h08;
	localparam logic [7:0] A_MMD_DATA = 8'h0c;
	localparam int CMD_WRITE_BIT = 31;
	localparam int CMD_ADDR_LSB = 16;
	localparam int CMD_ADDR_MSB = 20;
	localparam int ST_BUSY_BIT = 31;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : pvs_pkg

/* File: pkg/pvs_mgmt_if.sv */
`timescale 1ns/1ps
// Purpose: Parallel management access between controller and PHY bank
// Assumes: One clock shared by both ends
// Notes: req is a one-cycle pulse; ack answers it one cycle later
interface pvs_mgmt_if;
	logic req;
	logic we;
	logic [4:0] addr;
	logic [15:0] wdata;
	logic ack;
	logic [15:0] rdata;
	modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
	modport ctl (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface : pvs_mgmt_if

/* File: rtl/pvs_phy_regs.sv */
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Purpose: Vendor status, interrupt and MMD indirect access registers of the PHY
// Assumes: Event inputs are one-cycle pulses from PHY logic on clk
// Notes: Only the energy detector comes from the analog front end
module pvs_phy_regs #(
	parameter longint ENERGY_CYCLES = pvs_pkg::ENERGY_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Management side
	pvs_mgmt_if.dev m,
	// Receive path
	input wire logic rx_symbol_invalid,
	input wire logic rx_in_packet,
	input wire logic link_is_10m,
	input wire logic rx_polarity_reversed,
	input wire logic energy_detect_raw,
	// Negotiation and link events
	input wire logic an_done,
	input wire logic ev_an_complete,
	input wire logic ev_remote_fault,
	input wire logic ev_link_down,
	input wire logic ev_partner_ack,
	input wire logic ev_parallel_fault,
	input wire logic ev_page_received,
	input wire logic [2:0] resolved_speed_duplex,
	input wire logic auto_mdix_result,
	// Datapath controls
	output logic mdix_select,
	output logic sqe_test_enable,
	output logic coder_bypass,
	output logic line_energy_present,
	output logic irq
);
	typedef struct packed {
		logic [15:0] tally;
		logic pkt_counted;
		logic crossover_auto_disable;
		logic manual_pair_swap;
		logic heartbeat_test_off;
		logic coder_en;
		logic [6:0] flags;
		logic [6:0] mask;
		logic [1:0] mmd_fn;
		logic [4:0] mmd_device_select;
		logic [15:0] ptr;
		logic [pvs_pkg::MMD_SLOTS-1:0][15:0] mmd;
		logic [2:0] e_sync;
		logic e_filt;
		logic [24:0] e_cnt;
		logic energy;
		logic mdix;
		logic sqe_en;
		logic bypass;
		logic irq;
		logic ack;
		logic [15:0] rdata;
	} pvs_dev_st_t;

	pvs_dev_st_t q;
	pvs_dev_st_t d;
	logic [6:0] ev;
	logic [4:0] slot;
	logic [15:0] rd;

	localparam logic [24:0] E_LIMIT = 25'(ENERGY_CYCLES - 1);

	// ==========================================
	// MMD slot lookup
	function automatic logic [4:0] mmd_slot(input logic [4:0] dv, input logic [15:0] ix);
		logic [4:0] s;
		s = pvs_pkg::MMD_NONE;
		for (int i = 0; i < pvs_pkg::MMD_SLOTS; i++)
		begin
			if (pvs_pkg::MMD_MAP[i] == {dv, ix})
			begin
				s = 5'(i);
			end
		end
		return s;
	endfunction : mmd_slot

	// ==========================================
	// Next state
	always_comb
	begin
		d = q;
		d.ack = 1'b0;
		// Energy detector: three-stage sync, accept once last two agree
		d.e_sync = {q.e_sync[1:0], energy_detect_raw};
		if (q.e_sync[1] == q.e_sync[2])
		begin
			d.e_filt = q.e_sync[2];
		end
		if (q.e_filt)
		begin
			d.e_cnt = '0;
			d.energy = 1'b1;
		end
		else if (q.e_cnt == E_LIMIT)
		begin
			d.energy = 1'b0;
		end
		else
		begin
			d.e_cnt = q.e_cnt + 25'h0000001;
		end
		// Symbol faults; a packet's count is armed again between packets
		if (!rx_in_packet)
		begin
			d.pkt_counted = 1'b0;
		end
		if (rx_symbol_invalid && !link_is_10m)
		begin
			if (!rx_in_packet)
			begin
				d.tally = q.tally + 16'h0001;
			end
			else if (!q.pkt_counted)
			begin
				d.tally = q.tally + 16'h0001;
				d.pkt_counted = 1'b1;
			end
		end
		// Event vector in flag bit order 7 down to 1
		ev = {q.energy & ~d.energy, ev_an_complete, ev_remote_fault, ev_link_down,
			ev_partner_ack, ev_parallel_fault, ev_page_received};
		slot = mmd_slot(q.mmd_device_select, q.ptr);
		rd = '0;
		if (m.req)
		begin
			d.ack = 1'b1;
			case (m.addr)
				pvs_pkg::ADDR_SYM: rd = q.tally;
				pvs_pkg::ADDR_XOVER:
				begin
					rd[pvs_pkg::XOVER_AUTO_DIS_BIT] = q.crossover_auto_disable;
					rd[pvs_pkg::PAIR_SWAP_BIT] = q.manual_pair_swap;
					rd[pvs_pkg::SQE_OFF_BIT] = q.heartbeat_test_off;
					rd[pvs_pkg::POL_BIT] = rx_polarity_reversed;
					if (m.we)
					begin
						d.crossover_auto_disable = m.wdata[pvs_pkg::XOVER_AUTO_DIS_BIT];
						d.manual_pair_swap = m.wdata[pvs_pkg::PAIR_SWAP_BIT];
						d.heartbeat_test_off = m.wdata[pvs_pkg::SQE_OFF_BIT];
					end
				end
				pvs_pkg::ADDR_FLAGS:
				begin
					rd[pvs_pkg::FLAG_MSB:pvs_pkg::FLAG_LSB] = q.flags;
					d.flags = '0;
				end
				pvs_pkg::ADDR_MASK:
				begin
					rd[pvs_pkg::FLAG_MSB:pvs_pkg::FLAG_LSB] = q.mask;
					if (m.we)
					begin
						d.mask = m.wdata[pvs_pkg::FLAG_MSB:pvs_pkg::FLAG_LSB];
					end
				end
				pvs_pkg::ADDR_STAT:
				begin
					rd[pvs_pkg::DONE_BIT] = an_done;
					rd[pvs_pkg::CODER_BIT] = q.coder_en;
					rd[pvs_pkg::SPD_MSB:pvs_pkg::SPD_LSB] = resolved_speed_duplex;
					if (m.we)
					begin
						d.coder_en = m.wdata[pvs_pkg::CODER_BIT];
					end
				end
				pvs_pkg::ADDR_MMD_CTRL:
				begin
					rd[pvs_pkg::FN_MSB:pvs_pkg::FN_LSB] = q.mmd_fn;
					rd[pvs_pkg::MMD_DEVICE_SELECT_MSB:0] = q.mmd_device_select;
					if (m.we)
					begin
						d.mmd_fn = m.wdata[pvs_pkg::FN_MSB:pvs_pkg::FN_LSB];
						d.mmd_device_select = m.wdata[pvs_pkg::MMD_DEVICE_SELECT_MSB:0];
					end
				end
				pvs_pkg::ADDR_MMD_DATA:
				begin
					if (q.mmd_fn == pvs_pkg::FN_ADDR)
					begin
						rd = q.ptr;
						if (m.we)
						begin
							d.ptr = m.wdata;
						end
					end
					else if (slot != pvs_pkg::MMD_NONE)
					begin
						rd = q.mmd[slot];
						if (m.we)
						begin
							d.mmd[slot] = m.wdata;
						end
					end
				end
				default: rd = '0;
			endcase
		end
		// Read data holds until the next answer
		if (m.req)
		begin
			d.rdata = rd;
		end
		// Set wins over a read clear in the same cycle
		d.flags = d.flags | ev;
		d.irq = |(d.flags & d.mask);
		d.mdix = q.crossover_auto_disable ? q.manual_pair_swap : auto_mdix_result;
		d.sqe_en = ~d.heartbeat_test_off;
		d.bypass = ~d.coder_en;
	end

	// ==========================================
	// State register
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q <= '0;
			q.tally <= pvs_pkg::SYM_RST;
			q.coder_en <= 1'b1;
			q.mask <= pvs_pkg::MASK_RST;
			q.mmd <= pvs_pkg::MMD_RST;
			q.energy <= 1'b1;
			q.sqe_en <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	assign m.ack = q.ack;
	assign m.rdata = q.rdata;
	assign mdix_select = q.mdix;
	assign sqe_test_enable = q.sqe_en;
	assign coder_bypass = q.bypass;
	assign line_energy_present = q.energy;
	assign irq = q.irq;
endmodule : pvs_phy_regs

/* File: rtl/pvs_mgmt_ctl.sv */
`timescale 1ns/1ps
// Purpose: Station management controller reaching the PHY bank from AHB-Lite
// Assumes: Single AHB master, word transfers only, zero wait states
// Notes: Commands written while busy are dropped; poll STATUS busy first
module pvs_mgmt_ctl (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// PHY management side
	pvs_mgmt_if.ctl m
);
	typedef struct packed {
		logic ap_write;
		logic [7:0] ap_addr;
		logic busy;
		logic mmd;
		logic mwrite;
		logic [1:0] step;
		logic [4:0] mdevad;
		logic [15:0] mindex;
		logic [15:0] mdata;
		logic [15:0] last;
		logic req;
		logic we;
		logic [4:0] addr;
		logic [15:0] wdata;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} pvs_ctl_st_t;

	pvs_ctl_st_t q;
	pvs_ctl_st_t d;

	// ==========================================
	// One step of the four-access MMD sequence: three writes, then a read or write of data
	function automatic logic [21:0] mmd_step(input pvs_ctl_st_t s, input logic [1:0] st);
		logic [15:0] w;
		w = '0;
		w[pvs_pkg::MMD_DEVICE_SELECT_MSB:0] = s.mdevad;
		case (st)
			2'h0: return {1'b1, pvs_pkg::ADDR_MMD_CTRL, w};
			2'h1: return {1'b1, pvs_pkg::ADDR_MMD_DATA, s.mindex};
			2'h2:
			begin
				w[pvs_pkg::FN_MSB:pvs_pkg::FN_LSB] = pvs_pkg::FN_DATA;
				return {1'b1, pvs_pkg::ADDR_MMD_CTRL, w};
			end
			default: return {s.mwrite, pvs_pkg::ADDR_MMD_DATA, s.mdata};
		endcase
	endfunction : mmd_step

	always_comb
	begin
		d = q;
		d.req = 1'b0;
		// Zero wait states and always OKAY, still held in flops
		d.hreadyout = 1'b1;
		d.hresp = 1'b0;
		// Address phase: remember writes, answer reads in the next cycle
		d.ap_write = hsel && hready && htrans == pvs_pkg::HTRANS_NONSEQ && hwrite;
		d.ap_addr = haddr[7:0];
		if (hsel && hready && htrans == pvs_pkg::HTRANS_NONSEQ && !hwrite)
		begin
			d.hrdata = '0;
			case (haddr[7:0])
				pvs_pkg::A_STATUS:
				begin
					d.hrdata[pvs_pkg::ST_BUSY_BIT] = q.busy;
					d.hrdata[15:0] = q.last;
				end
				pvs_pkg::A_MMD_DATA: d.hrdata[15:0] = q.mdata;
				default: d.hrdata = '0;
			endcase
		end
		// Completion of a management access
		if (m.ack)
		begin
			d.last = m.rdata;
			if (q.mmd && q.step != 2'h3)
			begin
				d.step = q.step + 2'h1;
				{d.we, d.addr, d.wdata} = mmd_step(q, d.step);
				d.req = 1'b1;
			end
			else
			begin
				d.busy = 1'b0;
				if (q.mmd && !q.mwrite)
				begin
					d.mdata = m.rdata;
				end
			end
		end
		// Data phase of a write
		if (q.ap_write && !q.busy)
		begin
			case (q.ap_addr)
				pvs_pkg::A_CMD:
				begin
					d.we = hwdata[pvs_pkg::CMD_WRITE_BIT];
					d.addr = hwdata[pvs_pkg::CMD_ADDR_MSB:pvs_pkg::CMD_ADDR_LSB];
					d.wdata = hwdata[15:0];
					d.req = 1'b1;
					d.busy = 1'b1;
					d.mmd = 1'b0;
				end
				pvs_pkg::A_MMD_OP:
				begin
					d.mwrite = hwdata[pvs_pkg::CMD_WRITE_BIT];
					d.mdevad = hwdata[pvs_pkg::CMD_ADDR_MSB:pvs_pkg::CMD_ADDR_LSB];
					d.mindex = hwdata[15:0];
					d.mmd = 1'b1;
					d.busy = 1'b1;
					d.step = 2'h0;
					{d.we, d.addr, d.wdata} = mmd_step(d, 2'h0);
					d.req = 1'b1;
				end
				pvs_pkg::A_MMD_DATA: d.mdata = hwdata[15:0];
				default: d.mdata = q.mdata;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q <= '0;
			q.hreadyout <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	assign hreadyout = q.hreadyout;
	assign hresp = q.hresp;
	assign hrdata = q.hrdata;
	assign m.req = q.req;
	assign m.we = q.we;
	assign m.addr = q.addr;
	assign m.wdata = q.wdata;
endmodule : pvs_mgmt_ctl

/* File: verification/pvs_monitor.sv */
`timescale 1ns/1ps
// Purpose: Protocol checks on the management link between the two ends
// Assumes: One clock, rst_b async active low
// Notes: Sees only link signals; register contents are judged by the bench
module pvs_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Management link
	input wire logic req,
	input wire logic we,
	input wire logic [4:0] addr,
	input wire logic [15:0] wdata,
	input wire logic ack,
	input wire logic [15:0] rdata
);
	// ==========================================
	// Link timing and MMD sequence
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	AST_ACK_NEXT: assert property (req |=> ack) else $error("ack missing");
	AST_ACK_CAUSE: assert property (ack |-> $past(req)) else $error("stray ack");
	AST_ONE_OPEN: assert property (req |=> !req) else $error("request overlap");
	AST_RDATA_HOLD: assert property (!ack |-> $stable(rdata)) else $error("rdata moved");
	AST_STEP_INDEX: assert property (req && we && addr == pvs_pkg::ADDR_MMD_CTRL
		&& wdata[15:14] == pvs_pkg::FN_ADDR |-> ##2 req && we && addr == pvs_pkg::ADDR_MMD_DATA)
		else $error("index write missing");
	AST_STEP_DATA_FN: assert property (req && we && addr == pvs_pkg::ADDR_MMD_CTRL
		&& wdata[15:14] == pvs_pkg::FN_ADDR |-> ##4 req && we && addr == pvs_pkg::ADDR_MMD_CTRL
		&& wdata[15:14] == pvs_pkg::FN_DATA && wdata[4:0] == $past(wdata[4:0], 4))
		else $error("data function write wrong");
	AST_STEP_ACCESS: assert property (req && we && addr == pvs_pkg::ADDR_MMD_CTRL
		&& wdata[15:14] == pvs_pkg::FN_DATA |=> ##1 req && addr == pvs_pkg::ADDR_MMD_DATA)
		else $error("data access missing");
	// Reserved bits read zero
	AST_FLAG_RSVD: assert property (ack && !$past(we) && $past(addr) == pvs_pkg::ADDR_FLAGS
		|-> rdata[15:8] == 8'h00 && !rdata[0]) else $error("flag reserved set");
	AST_STAT_RSVD: assert property (ack && !$past(we) && $past(addr) == pvs_pkg::ADDR_STAT
		|-> rdata[15:13] == 3'h0 && rdata[11:7] == 5'h00 && !rdata[5] && rdata[1:0] == 2'h0)
		else $error("status reserved set");
endmodule : pvs_monitor

/* File: verification/phy_vendor_status_and_mmd_access_test.sv */
`timescale 1ns/1ps
// Purpose: Self-checking bench, AHB-Lite master to controller to PHY bank
// Assumes: ENERGY_CYCLES shortened to 16
// Notes: Integer model of tally, flags and mask
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module phy_vendor_status_and_mmd_access_test;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hready, hreadyout, hresp, mdix, sqe_en, bypass, lep, irq;
	logic [31:0] hrdata, t;
	logic sym_bad = 0, in_pkt = 0, is10 = 0, pol = 0, energy = 1, an_done = 0, amdix = 0;
	logic [5:0] ev = 6'h0;
	logic [2:0] spd = 3'h1;
	logic [2:0] sc [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
	logic [4:0] dv [5] = '{5'h03, 5'h07, 5'h1e, 5'h01, 5'h03};
	logic [15:0] ix [5] = '{16'h14, 16'h3d, 16'h0e, 16'h00, 16'h07};
	logic [15:0] r, d;
	int error_cnt = 0, n_compared = 0, seed = 33, sym = 0, flags, mask, i;
	pvs_mgmt_if mif ();
	assign hready = hreadyout;
	always #4 clk = ~clk;
	pvs_mgmt_ctl pvs_mgmt_ctl_inst (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .m(mif.ctl));
	pvs_phy_regs #(.ENERGY_CYCLES(16)) pvs_phy_regs_inst (.clk(clk), .rst_b(rst_b), .m(mif.dev),
		.rx_symbol_invalid(sym_bad), .rx_in_packet(in_pkt), .link_is_10m(is10),
		.rx_polarity_reversed(pol), .energy_detect_raw(energy), .an_done(an_done),
		.ev_an_complete(ev[5]), .ev_remote_fault(ev[4]), .ev_link_down(ev[3]),
		.ev_partner_ack(ev[2]), .ev_parallel_fault(ev[1]), .ev_page_received(ev[0]),
		.resolved_speed_duplex(spd), .auto_mdix_result(amdix), .mdix_select(mdix),
		.sqe_test_enable(sqe_en), .coder_bypass(bypass), .line_energy_present(lep), .irq(irq));
	pvs_monitor pvs_monitor_inst (.clk(clk), .rst_b(rst_b), .req(mif.req), .we(mif.we),
		.addr(mif.addr), .wdata(mif.wdata), .ack(mif.ack), .rdata(mif.rdata));
	// ==========================================
	// Bus tasks
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] dd);
		hsel <= 1'b1;
		htrans <= pvs_pkg::HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge clk);
		while (!hreadyout) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= dd;
		@(posedge clk);
		while (!hreadyout) @(posedge clk);
		t = hrdata;
	endtask : ahb
	task automatic busy();
		t = 32'h8000_0000;
		while (t[pvs_pkg::ST_BUSY_BIT] !== 1'b0) ahb(1'b0, pvs_pkg::A_STATUS, 32'h0);
	endtask : busy
	task automatic mg(input logic w, input logic [4:0] x, input logic [15:0] dd);
		ahb(1'b1, pvs_pkg::A_CMD, {w, 10'h0, x, dd});
		busy();
		r = t[15:0];
	endtask : mg
	task automatic mmd(input logic w, input logic [4:0] dev, input logic [15:0] x);
		ahb(1'b1, pvs_pkg::A_MMD_DATA, {16'h0, d});
		ahb(1'b1, pvs_pkg::A_MMD_OP, {w, 10'h0, dev, x});
		busy();
		ahb(1'b0, pvs_pkg::A_MMD_DATA, 32'h0);
		r = t[15:0];
	endtask : mmd
	task automatic bad(input int n);
		repeat (n)
		begin
			sym_bad <= 1'b1;
			@(posedge clk);
		end
		sym_bad <= 1'b0;
		@(posedge clk);
	endtask : bad
	task automatic report_and_stop();
		if (error_cnt == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	// ==========================================
	// Scenarios
	initial
	begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		mg(1'b0, pvs_pkg::ADDR_SYM, 16'h0);
		`CHK(r, 16'h0000);
		mg(1'b0, pvs_pkg::ADDR_MASK, 16'h0);
		`CHK(r, 16'h0000);
		for (i = 0; i < 4; i++)
		begin
			spd <= sc[i];
			an_done <= i[0];
			mg(1'b0, pvs_pkg::ADDR_STAT, 16'h0);
			`CHK(r, {3'h0, i[0], 5'h0, 1'b1, 1'b0, sc[i], 2'h0});
		end
		`CHK(bypass, 1'b0);
		mg(1'b1, pvs_pkg::ADDR_STAT, 16'h0);
		`CHK(bypass, 1'b1);
		mg(1'b1, pvs_pkg::ADDR_STAT, 16'h0040);
		mg(1'b0, pvs_pkg::ADDR_STAT, 16'h0);
		`CHK(r[6], 1'b1);
		`CHK(bypass, 1'b0);
		for (i = 0; i < 8; i++)
		begin
			amdix <= $random(seed);
			pol <= $random(seed);
			mg(1'b1, pvs_pkg::ADDR_XOVER, {i[2], 1'b0, i[1], 1'b0, i[0], 11'h7ff});
			mg(1'b0, pvs_pkg::ADDR_XOVER, 16'h0);
			`CHK(r, {i[2], 1'b0, i[1], 1'b0, i[0], 6'h0, pol, 4'h0});
			`CHK(mdix, i[2] ? i[1] : amdix);
			`CHK(sqe_en, ~i[0]);
		end
		// Idle faults count each, a packet once, 10M not at all
		bad(3);
		in_pkt <= 1'b1;
		bad(4);
		in_pkt <= 1'b0;
		is10 <= 1'b1;
		bad(5);
		is10 <= 1'b0;
		sym = 4;
		mg(1'b0, pvs_pkg::ADDR_SYM, 16'h0);
		`CHK(r, sym[15:0]);
		mg(1'b0, pvs_pkg::ADDR_SYM, 16'h0);
		`CHK(r, sym[15:0]);
		bad(65532);
		sym = (sym + 65532) % 65536;
		mg(1'b0, pvs_pkg::ADDR_SYM, 16'h0);
		`CHK(r, sym[15:0]);
		for (i = 0; i < 6; i++)
		begin
			mask = $random(seed) & 32'hfe;
			flags = ($random(seed) & 32'h3f) << 1;
			mg(1'b1, pvs_pkg::ADDR_MASK, mask[15:0]);
			mg(1'b0, pvs_pkg::ADDR_MASK, 16'h0);
			`CHK(r, mask[15:0]);
			ev <= flags[6:1];
			@(posedge clk);
			ev <= 6'h0;
			repeat (3) @(posedge clk);
			`CHK(irq, |(flags & mask));
			mg(1'b0, pvs_pkg::ADDR_FLAGS, 16'h0);
			`CHK(r, flags[15:0]);
			mg(1'b0, pvs_pkg::ADDR_FLAGS, 16'h0);
			`CHK(r, 16'h0000);
			`CHK(irq, 1'b0);
		end
		`CHK(lep, 1'b1);
		energy <= 1'b0;
		repeat (30) @(posedge clk);
		`CHK(lep, 1'b0);
		mg(1'b0, pvs_pkg::ADDR_FLAGS, 16'h0);
		`CHK(r, 16'h0080);
		energy <= 1'b1;
		d = 16'h0;
		mmd(1'b0, 5'h03, 16'h5);
		`CHK(r, 16'h0088);
		mmd(1'b0, 5'h03, 16'h6);
		`CHK(r, 16'h4000);
		for (i = 0; i < 5; i++)
		begin
			d = $random(seed);
			mmd(1'b1, dv[i], ix[i]);
			mmd(1'b0, dv[i], ix[i]);
			`CHK(r, (i < 3) ? d : 16'h0);
		end
		mg(1'b1, 5'h10, 16'hffff);
		`CHK(r, 16'h0000);
		ahb(1'b0, 8'h10, 32'h0);
		`CHK(t, 32'h0);
		`CHK(hresp, 1'b0);
		report_and_stop();
	end
	initial
	begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
endmodule : phy_vendor_status_and_mmd_access_test
